/* File: design/fmc_pkg.sv */
// shared constants and helpers for the fifo mode, configuration and flag block
package fmc_pkg;

  // data path geometry
  localparam int DATA_W     = 18;
  localparam int BYTE_W     = 9;
  localparam int PARITY_BIT = 8;
  localparam int OFS_W      = 8;
  localparam int DEPTH_DEF  = 16;

  // field positions of the parallel offset word
  localparam int OFS_HI_MSB = 16;
  localparam int OFS_HI_LSB = 9;
  localparam int OFS_LO_MSB = 7;
  localparam int PLAIN_MSB  = 15;

  // width of the gray helpers; pointers are cast into it
  localparam int GW = 16;

  // sampled configuration, one bit per strap pin plus the two preset selects and the load enable
  typedef struct packed {
    logic       rd_sync;      // read port synchronous
    logic       wr_sync;      // write port synchronous
    logic       little_end;   // byte order
    logic       first_word_passthrough_mode;         // first word passthrough mode
    logic       inter_par;    // interspersed parity
    logic       in_x9;        // write port 9 bits
    logic       out_x9;       // read port 9 bits
    logic [2:0] preset;       // {sel1, sel0, load enable}
  } fmc_cfg_t;

  // configuration after the plain reset, before any master reset
  localparam fmc_cfg_t CFG_RST = '{rd_sync: 1'b1, wr_sync: 1'b1, little_end: 1'b0, first_word_passthrough_mode: 1'b0,
                                   inter_par: 1'b0, in_x9: 1'b0, out_x9: 1'b0, preset: 3'h0};

  // eight default offsets chosen by the preset selects and the load enable (plain values)
  localparam logic [OFS_W-1:0] PRESET_OFS [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                                  8'h05, 8'h06, 8'h07, 8'h08};

  // reset values of the flag outputs and the data register
  localparam logic              FLAG_RST = 1'b0;
  localparam logic [DATA_W-1:0] DOUT_RST = 18'h00000;

  function automatic logic [GW-1:0] gray_enc(input logic [GW-1:0] b);
    gray_enc = b ^ (b >> 1);
  endfunction

  function automatic logic [GW-1:0] gray_dec(input logic [GW-1:0] g);
    logic [GW-1:0] b;
    b = g;
    for (int i = GW - 2; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    gray_dec = b;
  endfunction

endpackage

/* File: design/fmc_fifo_cfg_flags.sv */
`timescale 1ns/100ps
module fmc_fifo_cfg_flags
  import fmc_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              ce_in,
  input  wire logic              rd_clk_in,
  input  wire logic              rd_rst_b_in,
  input  wire logic              global_init_b_in,
  input  wire logic              read_port_timing_sel_in,
  input  wire logic              write_port_timing_sel_in,
  input  wire logic              byte_order_sel_in,
  input  wire logic              fallthrough_sel_serial_in,
  input  wire logic              parity_position_sel_in,
  input  wire logic              input_width_sel_in,
  input  wire logic              output_width_sel_in,
  input  wire logic              offset_preset_sel_0_in,
  input  wire logic              offset_preset_sel_1_in,
  input  wire logic              offset_load_enable_b_in,
  input  wire logic              serial_enable_b_in,
  input  wire logic              wr_en_in,
  input  wire logic [DATA_W-1:0] write_data_bus_in,
  input  wire logic              rd_en_in,
  output logic [DATA_W-1:0]      rd_data_out,
  output logic                   empty_or_valid_out,
  output logic                   full_or_space_out,
  output logic                   half_full_indicator_out,
  output logic                   read_clock_echo_out,
  output logic                   read_enable_echo_out,
  output logic [OFS_W-1:0]       empty_offset_out,
  output logic [OFS_W-1:0]       full_offset_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_P  = PW'(DEPTH / 2);
  localparam logic [PW-1:0] ONE_P   = PW'(1);

  // write domain state, clocked by clk_in
  typedef struct packed {
    logic                         init_s1;
    logic                         init_s2;
    fmc_cfg_t                     pin_s1;
    fmc_cfg_t                     pin_s2;
    logic [PW-1:0]                rg_s1;
    logic [PW-1:0]                rg_s2;
    logic                         stb_s1;
    logic                         stb_s2;
    logic                         stb_s3;
    fmc_cfg_t                     cfg;
    logic [PW-1:0]                wptr;
    logic [PW-1:0]                wptr_g;
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [OFS_W-1:0]             eofs;
    logic [OFS_W-1:0]             fofs;
    logic                         ofs_sel;
    logic                         fs;
    logic                         hf;
  } fmc_wr_t;

  // read domain state, clocked by rd_clk_in
  typedef struct packed {
    logic              init_s1;
    logic              init_s2;
    fmc_cfg_t          cfg_s1;
    fmc_cfg_t          cfg_s2;
    logic              ce_s1;
    logic              ce_s2;
    logic [PW-1:0]     wg_s1;
    logic [PW-1:0]     wg_s2;
    logic              stb_s1;
    logic              stb_s2;
    logic              stb_s3;
    logic [PW-1:0]     rptr;
    logic [PW-1:0]     rptr_g;
    logic              phase;
    logic              valid;
    logic [DATA_W-1:0] dout;
    logic              ev;
    logic              echo_clk;
    logic              echo_en;
  } fmc_rd_t;

  fmc_wr_t w_r;
  fmc_wr_t w_nxt;
  fmc_rd_t r_r;
  fmc_rd_t r_nxt;

  // write side: strap capture, memory writes, offset loading, full and half flags
  always_comb begin
    logic          wgo;
    logic [PW-1:0] rbin;
    logic [PW-1:0] cnt;
    logic [15:0]   pval;
    logic          full_now;
    logic [GW-1:0] gfull;
    wgo      = 1'b0;
    gfull    = '0;
    rbin     = '0;
    cnt      = '0;
    pval     = '0;
    full_now = 1'b0;
    w_nxt    = w_r;
    if (!rst_b_in) begin
      w_nxt     = '0;
      w_nxt.cfg = CFG_RST;
      w_nxt.fs  = FLAG_RST;
      w_nxt.hf  = FLAG_RST;
    end else if (ce_in) begin
      // two-stage capture of the strap pins and the foreign pointer
      w_nxt.init_s1 = global_init_b_in;
      w_nxt.init_s2 = w_r.init_s1;
      w_nxt.pin_s1  = '{rd_sync: read_port_timing_sel_in, wr_sync: write_port_timing_sel_in,
                        little_end: byte_order_sel_in, first_word_passthrough_mode: fallthrough_sel_serial_in,
                        inter_par: parity_position_sel_in, in_x9: input_width_sel_in,
                        out_x9: output_width_sel_in,
                        preset: {offset_preset_sel_1_in, offset_preset_sel_0_in, offset_load_enable_b_in}};
      w_nxt.pin_s2  = w_r.pin_s1;
      w_nxt.rg_s1   = r_r.rptr_g;
      w_nxt.rg_s2   = w_r.rg_s1;
      w_nxt.stb_s1  = wr_en_in;
      w_nxt.stb_s2  = w_r.stb_s1;
      w_nxt.stb_s3  = w_r.stb_s2;
      // asynchronous port: one write per rising strobe edge seen through the synchroniser
      wgo = w_r.cfg.wr_sync ? wr_en_in : (w_r.stb_s2 & ~w_r.stb_s3);
      gfull = gray_dec(GW'(w_r.rg_s2));
      rbin = gfull[PW-1:0];
      full_now = ((w_r.wptr - rbin) == DEPTH_P);
      if (!w_r.init_s2) begin
        // straps follow the pins for as long as master reset is held
        w_nxt.cfg     = w_r.pin_s2;
        w_nxt.wptr    = '0;
        w_nxt.eofs    = PRESET_OFS[w_r.pin_s2.preset];
        w_nxt.fofs    = PRESET_OFS[w_r.pin_s2.preset];
        w_nxt.ofs_sel = 1'b0;
      end else begin
        // cfg is left alone here, so it holds until the next master reset
        w_nxt.cfg = w_r.cfg;
        if (wgo && !offset_load_enable_b_in) begin
          // parallel offset load: empty offset first, full offset next
          if (w_r.cfg.inter_par && !w_r.cfg.in_x9) begin
            pval = {write_data_bus_in[OFS_HI_MSB:OFS_HI_LSB], write_data_bus_in[OFS_LO_MSB:0]};
          end else begin
            pval = write_data_bus_in[PLAIN_MSB:0];
          end
          if (w_r.ofs_sel) begin
            w_nxt.fofs = pval[OFS_W-1:0];
          end else begin
            w_nxt.eofs = pval[OFS_W-1:0];
          end
          w_nxt.ofs_sel = ~w_r.ofs_sel;
        end else if (wgo && offset_load_enable_b_in && !full_now) begin
          // memory write only while load is high; full drops the word
          w_nxt.mem[w_r.wptr[AW-1:0]] = w_r.cfg.in_x9 ?
            {{(DATA_W-BYTE_W){1'b0}}, write_data_bus_in[BYTE_W-1:0]} : write_data_bus_in;
          w_nxt.wptr = w_r.wptr + ONE_P;
        end else if (!serial_enable_b_in && !offset_load_enable_b_in) begin
          // serial load shifts through empty then full offset
          {w_nxt.eofs, w_nxt.fofs} = {w_r.eofs[OFS_W-2:0], w_r.fofs, w_r.pin_s2.first_word_passthrough_mode};
        end
      end
      // flags from the updated write pointer; the read pointer lags, so full is pessimistic
      cnt = w_nxt.wptr - rbin;
      w_nxt.fs = w_nxt.cfg.first_word_passthrough_mode ? (cnt != DEPTH_P) : (cnt == DEPTH_P);
      w_nxt.hf = (cnt > HALF_P);
      gfull = gray_enc(GW'(w_nxt.wptr));
      w_nxt.wptr_g = gfull[PW-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    w_r <= w_nxt;
  end

  // read side: byte order, standard or passthrough output, empty/valid flag, echoes
  always_comb begin
    logic              rgo;
    logic              have;
    logic              split;
    logic              take;
    logic [PW-1:0]     wbin;
    logic [DATA_W-1:0] word;
    logic [BYTE_W-1:0] bsel;
    logic [DATA_W-1:0] outw;
    logic [GW-1:0]     gfull;
    gfull = '0;
    rgo   = 1'b0;
    have  = 1'b0;
    split = 1'b0;
    take  = 1'b0;
    wbin  = '0;
    word  = '0;
    bsel  = '0;
    outw  = '0;
    r_nxt = r_r;
    if (!rd_rst_b_in) begin
      r_nxt        = '0;
      r_nxt.cfg_s1 = CFG_RST;
      r_nxt.cfg_s2 = CFG_RST;
      r_nxt.dout   = DOUT_RST;
      r_nxt.ev     = FLAG_RST;
    end else begin
      // the clock enable itself crosses as a level; its synchroniser never freezes
      r_nxt.ce_s1 = ce_in;
      r_nxt.ce_s2 = r_r.ce_s1;
      if (r_r.ce_s2) begin
        r_nxt.init_s1 = global_init_b_in;
        r_nxt.init_s2 = r_r.init_s1;
        // cfg only moves under master reset, so a level crossing is safe
        r_nxt.cfg_s1  = w_r.cfg;
        r_nxt.cfg_s2  = r_r.cfg_s1;
        r_nxt.wg_s1   = w_r.wptr_g;
        r_nxt.wg_s2   = r_r.wg_s1;
        r_nxt.stb_s1  = rd_en_in;
        r_nxt.stb_s2  = r_r.stb_s1;
        r_nxt.stb_s3  = r_r.stb_s2;
        rgo   = r_r.cfg_s2.rd_sync ? rd_en_in : (r_r.stb_s2 & ~r_r.stb_s3);
        gfull = gray_dec(GW'(r_r.wg_s2));
        wbin  = gfull[PW-1:0];
        have  = (wbin != r_r.rptr);
        split = r_r.cfg_s2.out_x9 && !r_r.cfg_s2.in_x9;
        word  = w_r.mem[r_r.rptr[AW-1:0]];
        // first byte out: upper for big endian, lower for little endian
        if (r_r.cfg_s2.little_end ^ r_r.phase) begin
          bsel = word[BYTE_W-1:0];
        end else begin
          bsel = word[DATA_W-1:BYTE_W];
        end
        outw = split ? {{(DATA_W-BYTE_W){1'b0}}, bsel} : word;
        if (!r_r.init_s2) begin
          r_nxt.rptr  = '0;
          r_nxt.phase = 1'b0;
          r_nxt.valid = 1'b0;
          r_nxt.dout  = DOUT_RST;
        end else if (r_r.cfg_s2.first_word_passthrough_mode) begin
          // passthrough: refill the output whenever it is empty or being consumed
          take = have && (!r_r.valid || rgo);
          if (take) begin
            r_nxt.valid = 1'b1;
          end else if (rgo) begin
            r_nxt.valid = 1'b0;
          end
        end else begin
          // a read is refused while the empty flag still shows empty, so the reader sees what it was told
          take = have && rgo && !r_r.ev;
        end
        if (take) begin
          r_nxt.dout = outw;
          if (split && !r_r.phase) begin
            r_nxt.phase = 1'b1;
          end else begin
            r_nxt.phase = 1'b0;
            r_nxt.rptr  = r_r.rptr + ONE_P;
          end
        end
        gfull = gray_enc(GW'(r_nxt.rptr));
        r_nxt.rptr_g = gfull[PW-1:0];
        if (r_r.cfg_s2.first_word_passthrough_mode) begin
          r_nxt.ev = r_nxt.valid;
        end else begin
          r_nxt.ev = (wbin == r_nxt.rptr);
        end
        // echoes are dead low while the read port is asynchronous
        r_nxt.echo_clk = r_r.cfg_s2.rd_sync & ~r_r.echo_clk;
        r_nxt.echo_en  = r_r.cfg_s2.rd_sync & rd_en_in;
      end
    end
  end

  always_ff @(posedge rd_clk_in) begin
    r_r <= r_nxt;
  end

  // every output comes straight from a state flop
  assign rd_data_out             = r_r.dout;
  assign empty_or_valid_out      = r_r.ev;
  assign full_or_space_out       = w_r.fs;
  assign half_full_indicator_out = w_r.hf;
  assign read_clock_echo_out     = r_r.echo_clk;
  assign read_enable_echo_out    = r_r.echo_en;
  assign empty_offset_out        = w_r.eofs;
  assign full_offset_out         = w_r.fofs;

endmodule

/* File: tb/fmc_cfg_sva.sv */
`timescale 1ns/100ps
// port checker for the mode, config and flag block
module fmc_cfg_sva
  import fmc_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              rst_b_in,
  input wire logic              rd_clk_in,
  input wire logic              rd_rst_b_in,
  input wire logic              global_init_b_in,
  input wire logic              read_port_timing_sel_in,
  input wire logic              fallthrough_sel_serial_in,
  input wire logic              offset_preset_sel_0_in,
  input wire logic              offset_preset_sel_1_in,
  input wire logic              offset_load_enable_b_in,
  input wire logic              rd_en_in,
  input wire logic [DATA_W-1:0] rd_data_out,
  input wire logic              empty_or_valid_out,
  input wire logic              full_or_space_out,
  input wire logic              half_full_indicator_out,
  input wire logic              read_clock_echo_out,
  input wire logic              read_enable_echo_out,
  input wire logic [OFS_W-1:0]  empty_offset_out,
  input wire logic [OFS_W-1:0]  full_offset_out
);
  logic [3:0] rc, wc;
  logic [2:0] wps;
  logic       rs, rft, wft, rdone, wdone;
  // straps seen in master reset; counters wait out both synchronisers before checking
  always_ff @(posedge rd_clk_in) begin
    if (!rd_rst_b_in) rc <= 4'h0;
    else if (!global_init_b_in) {rc, rs, rft} <= {4'h1, read_port_timing_sel_in, fallthrough_sel_serial_in};
    else if (rc != 4'h0 && rc != 4'hF) rc <= rc + 4'h1;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) wc <= 4'h0;
    else if (!global_init_b_in) {wc, wft, wps} <= {4'h1, fallthrough_sel_serial_in, offset_preset_sel_1_in,
                                                   offset_preset_sel_0_in, offset_load_enable_b_in};
    else if (wc != 4'h0 && wc != 4'hF) wc <= wc + 4'h1;
  end
  assign rdone = (rc == 4'hF);
  assign wdone = (wc == 4'hF);
  // config settles, then a read tried on an empty fifo that still shows empty the next cycle
  sequence s_wsettle;
    wc == 4'hE ##1 wc == 4'hF;
  endsequence
  sequence s_idle_rd;
    rdone && !rft && rd_en_in && empty_or_valid_out ##1 empty_or_valid_out;
  endsequence
  property p_echo_off; @(posedge rd_clk_in) disable iff (!rd_rst_b_in)
    rdone && !rs |-> !read_clock_echo_out && !read_enable_echo_out; endproperty
  a_echo_off: assert property (p_echo_off) else $error("echo active on async read port");
  property p_clk_echo; @(posedge rd_clk_in) disable iff (!rd_rst_b_in)
    rdone && rs |=> $changed(read_clock_echo_out); endproperty
  a_clk_echo: assert property (p_clk_echo) else $error("read clock echo stuck");
  property p_en_echo; @(posedge rd_clk_in) disable iff (!rd_rst_b_in)
    rdone && rs |-> read_enable_echo_out == $past(rd_en_in); endproperty
  a_en_echo: assert property (p_en_echo) else $error("read enable echo wrong");
  property p_empty_ign; @(posedge rd_clk_in) disable iff (!rd_rst_b_in)
    s_idle_rd |-> $stable(rd_data_out); endproperty
  a_empty_ign: assert property (p_empty_ign) else $error("data moved while empty");
  property p_valid_hold; @(posedge rd_clk_in) disable iff (!rd_rst_b_in)
    rdone && rft && empty_or_valid_out && !rd_en_in |=> empty_or_valid_out; endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid lost without a read");
  property p_nospace; @(posedge clk_in) disable iff (!rst_b_in)
    wdone && (full_or_space_out ^ wft) |-> half_full_indicator_out; endproperty
  a_nospace: assert property (p_nospace) else $error("no space but not half full");
  property p_preset; @(posedge clk_in) disable iff (!rst_b_in)
    s_wsettle |-> empty_offset_out == PRESET_OFS[wps] && full_offset_out == PRESET_OFS[wps]; endproperty
  a_preset: assert property (p_preset) else $error("default offset wrong");
  property p_ofs_hold; @(posedge clk_in) disable iff (!rst_b_in)
    wdone && offset_load_enable_b_in |=> $stable(empty_offset_out) && $stable(full_offset_out); endproperty
  a_ofs_hold: assert property (p_ofs_hold) else $error("offsets moved without load");
endmodule

bind fmc_fifo_cfg_flags fmc_cfg_sva u_sva (.*);

/* File: tb/fmc_rd_model.sv */
`timescale 1ns/100ps
// far-side reader: asks for a set count of words, stalls while empty
module fmc_rd_model (
  input  wire logic        rd_clk_in,
  input  wire logic        empty_in,
  input  wire logic [17:0] rd_data_in,
  output logic             rd_en_out
);
  logic [8:0] got [$];
  int         left = 0;
  logic       took = 1'b0;
  initial rd_en_out = 1'b0;
  // request held until taken; data picked up one edge later
  always @(posedge rd_clk_in) begin
    if (took)
      got.push_back(rd_data_in[8:0]);
    took <= rd_en_out && !empty_in;
    if (rd_en_out && !empty_in)
      left = left - 1;
    rd_en_out <= (left > 0);
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/100ps
// straps, writes and far-side reads against the config and flag block
module testbench;
  import fmc_pkg::*;
  localparam int DEPTH = 4;
  logic        clk_in = 1'b0, rd_clk_in = 1'b0, rst_b = 1'b0, init_b = 1'b1, we = 1'b0, rd_en;
  logic        rs = 1'b1, ws = 1'b1, be = 1'b0, ft = 1'b0, ip = 1'b0, iw = 1'b0, ow = 1'b0;
  logic        s1 = 1'b0, s0 = 1'b0, ld = 1'b1, ev, fs, hf, ck_e, en_e;
  logic [17:0] wd = 18'h00000, rdat;
  logic [7:0]  eofs, fofs;
  int          n_mismatch = 0, tests_run = 0, cyc = 0;
  // unrelated clocks, 50 ns and 48 ns
  initial forever #25 clk_in = ~clk_in;
  initial begin
    #7;
    forever #24 rd_clk_in = ~rd_clk_in;
  end
  // serial loading left out, so its enable stays off
  fmc_fifo_cfg_flags #(.DEPTH(DEPTH)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b), .ce_in(1'b1), .rd_clk_in(rd_clk_in), .rd_rst_b_in(rst_b),
    .global_init_b_in(init_b), .read_port_timing_sel_in(rs), .write_port_timing_sel_in(ws),
    .byte_order_sel_in(be), .fallthrough_sel_serial_in(ft), .parity_position_sel_in(ip),
    .input_width_sel_in(iw), .output_width_sel_in(ow), .offset_preset_sel_0_in(s0),
    .offset_preset_sel_1_in(s1), .offset_load_enable_b_in(ld), .serial_enable_b_in(1'b1),
    .wr_en_in(we), .write_data_bus_in(wd), .rd_en_in(rd_en), .rd_data_out(rdat),
    .empty_or_valid_out(ev), .full_or_space_out(fs), .half_full_indicator_out(hf),
    .read_clock_echo_out(ck_e), .read_enable_echo_out(en_e), .empty_offset_out(eofs),
    .full_offset_out(fofs));
  fmc_rd_model rdr (.rd_clk_in(rd_clk_in), .empty_in(ev), .rd_data_in(rdat), .rd_en_out(rd_en));
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // straps held past the release so the synchronisers catch them
  task automatic global_init(input logic [9:0] s);
    @(negedge clk_in);
    {rs, ws, be, ft, ip, iw, ow, s1, s0, ld} = s;
    init_b = 1'b0;
    repeat (6) @(negedge clk_in);
    init_b = 1'b1;
    repeat (3) @(negedge clk_in);
    {ft, ld} = 2'h1;
    repeat (20) @(negedge clk_in);
  endtask
  // back-to-back writes
  task automatic wrs(input int n, input logic [17:0] d);
    repeat (n) begin
      @(negedge clk_in);
      {we, wd} = {1'b1, d};
    end
    @(negedge clk_in);
    we = 1'b0;
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far above the two hundred or so cycles needed
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(negedge clk_in);
    rst_b = 1'b1;
    // sync ports, big endian, standard, x18 in, x9 out, preset 101
    global_init(10'h30D);
    chk("ofs", {2'h0, eofs, fofs}, {2'h0, PRESET_OFS[5], PRESET_OFS[5]});
    chk("flags", {ev, fs, hf}, 3'h4);
    rdr.left = 2;
    wrs(1, {9'h15A, 9'h0C7});
    repeat (20) @(negedge clk_in);
    chk("byte0", rdr.got[0], 9'h15A);
    chk("byte1", rdr.got[1], 9'h0C7);
    wrs(DEPTH - 1, 18'h00100);
    repeat (6) @(negedge clk_in);
    chk("flags", {ev, fs, hf}, 3'h1);
    wrs(2, 18'h00200);
    repeat (3) @(negedge clk_in);
    chk("full", fs, 1'b1);
    // async ports stay in standard timing, preset 111
    global_init(10'h087);
    {rs, be} = 2'h2;
    {we, wd} = {1'b1, 18'h00055};
    repeat (3) @(negedge clk_in);
    we = 1'b0;
    repeat (20) @(negedge clk_in);
    chk("echo", {ck_e, en_e}, 2'h0);
    chk("flags", {ev, fs, hf}, 3'h0);
    // sync ports, little endian, passthrough, interspersed parity, preset 010
    global_init(10'h3EA);
    chk("flags", {ev, fs}, 2'h1);
    wrs(1, {9'h15A, 9'h0C7});
    repeat (20) @(negedge clk_in);
    chk("valid", ev, 1'b1);
    chk("first", rdat[8:0], 9'h0C7);
    chk("ofs", {2'h0, eofs, fofs}, {2'h0, PRESET_OFS[2], PRESET_OFS[2]});
    tally_and_finish();
  end
endmodule
